// *** pec_defs.svh ***
/*
  Timing figures and derived cycle counts for the parallel memory host.
  Assumes a single system clock of CLK_MHZ and a byte-wide async memory.
*/
`ifndef PEC_DEFS_SVH
`define PEC_DEFS_SVH

`define PEC_CLK_MHZ      200
`define PEC_ADDR_W       17
`define PEC_DATA_W       8
`define PEC_POLL_BIT     7

// Least times in ns, rounded up to whole cycles.
`define PEC_T_ACC_NS     150
`define PEC_T_HZ_NS      50
`define PEC_T_WP_NS      100
`define PEC_T_WPH_NS     100
`define PEC_T_BLC_MIN_NS 200
`define PEC_CYC_ACC      ((`PEC_T_ACC_NS * `PEC_CLK_MHZ + 999) / 1000)
`define PEC_CYC_HZ       ((`PEC_T_HZ_NS * `PEC_CLK_MHZ + 999) / 1000)
`define PEC_CYC_WP       ((`PEC_T_WP_NS * `PEC_CLK_MHZ + 999) / 1000)
`define PEC_CYC_WPH      ((`PEC_T_WPH_NS * `PEC_CLK_MHZ + 999) / 1000)
`define PEC_CYC_BLC_MIN  ((`PEC_T_BLC_MIN_NS * `PEC_CLK_MHZ + 999) / 1000)

// Longest byte-load spacing rounds down; internal write time is a wait.
`define PEC_T_BLC_MAX_US 100
`define PEC_T_WC_MS      10
`define PEC_CYC_BLC_MAX  (`PEC_T_BLC_MAX_US * `PEC_CLK_MHZ)
`define PEC_CYC_WC       (`PEC_T_WC_MS * 1000 * `PEC_CLK_MHZ)
`define PEC_CYC_RD_ALL   (`PEC_CYC_ACC + `PEC_CYC_HZ)

`endif

// *** pec_pkg.sv ***
/*
  Types shared by the parallel memory host modules.
  Assumes pec_defs.svh holds the numeric constants.
*/
package pec_pkg;

  typedef enum logic [6:0]
  {
    PEC_IDLE = 7'b0000001,
    PEC_RACC = 7'b0000010,
    PEC_RREL = 7'b0000100,
    PEC_WPUL = 7'b0001000,
    PEC_WREC = 7'b0010000,
    PEC_LOAD = 7'b0100000,
    PEC_BUSY = 7'b1000000
  } pec_state_t;

endpackage

// *** pec_sync.sv ***
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs are asynchronous to clk_sys; output follows once the
  second and third stages agree.
*/
`timescale 1ns/1ps

module pec_sync
#(
  parameter int W = 8
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // The first stage feeds only the second; filtering starts after it.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

// *** pec_ctrl.sv ***
/*
  Host controller for a byte-wide self-timed nonvolatile memory: read,
  byte and page write, and completion polling over the data pins.
  Assumes the memory is asynchronous and the data pins are resolved
  outside from data_pins_out and data_pins_oe.
*/
`timescale 1ns/1ps
`include "pec_defs.svh"

module pec_ctrl
  import pec_pkg::*;
#(
  parameter int unsigned WC_CYC      = `PEC_CYC_WC,
  parameter int unsigned BLC_MAX_CYC = `PEC_CYC_BLC_MAX
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic                   req_write,
  input  wire logic                   req_last,
  input  wire logic [`PEC_ADDR_W-1:0] req_addr,
  input  wire logic [`PEC_DATA_W-1:0] req_wdata,
  input  wire logic                   poll_en,
  output logic                        rsp_valid,
  output logic      [`PEC_DATA_W-1:0] rsp_data,
  output logic                        wr_busy,
  output logic      [`PEC_ADDR_W-1:0] mem_addr,
  output logic                        mem_ce_b,
  output logic                        mem_oe_b,
  output logic                        mem_we_b,
  output logic      [`PEC_DATA_W-1:0] data_pins_out,
  output logic                        data_pins_oe,
  input  wire logic [`PEC_DATA_W-1:0] data_pins_in
);

  // ****************************************************************
  // State and synchronised inputs
  // ****************************************************************
  pec_state_t             state_reg,    state_next;
  logic [7:0]             ph_reg,       ph_next;
  logic [31:0]            blc_reg,      blc_next;
  logic [31:0]            wc_reg,       wc_next;
  logic                   busy_reg,     busy_next;
  logic                   poll_reg,     poll_next;
  logic                   open_reg,     open_next;
  logic                   last_reg,     last_next;
  logic                   pbit_reg,     pbit_next;
  logic                   wbit_reg,     wbit_next;
  logic [`PEC_ADDR_W-1:0] waddr_reg,    waddr_next;
  logic [`PEC_ADDR_W-1:0] addr_reg,     addr_next;
  logic [`PEC_DATA_W-1:0] wdat_reg,     wdat_next;
  logic [`PEC_DATA_W-1:0] rdat_reg,     rdat_next;
  logic                   rv_reg,       rv_next;
  logic                   ce_b_reg,     ce_b_next;
  logic                   oe_b_reg,     oe_b_next;
  logic                   we_b_reg,     we_b_next;
  logic                   doe_reg,      doe_next;
  logic [`PEC_DATA_W-1:0] din_sync;
  logic                   take;

  pec_sync
  #(
    .W (`PEC_DATA_W)
  )
  u_sync
  (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .async_in (data_pins_in),
    .sync_out (din_sync)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    ph_next    = ph_reg + 8'h01;
    blc_next   = blc_reg + 32'h1;
    wc_next    = busy_reg ? wc_reg + 32'h1 : wc_reg;
    busy_next  = busy_reg;
    poll_next  = poll_reg;
    open_next  = open_reg;
    last_next  = last_reg;
    pbit_next  = pbit_reg;
    wbit_next  = wbit_reg;
    waddr_next = waddr_reg;
    addr_next  = addr_reg;
    wdat_next  = wdat_reg;
    rdat_next  = rdat_reg;
    rv_next    = 1'b0;
    req_ready  = 1'b0;
    take       = 1'b0;
    case (state_reg)
      PEC_IDLE:
      begin
        req_ready = 1'b1;
        take      = req_valid;
      end
      PEC_LOAD:
      begin
        if (blc_reg >= 32'(`PEC_CYC_BLC_MIN - 1)
            && blc_reg < 32'(BLC_MAX_CYC - 1))
        begin
          req_ready = req_write
                      || blc_reg < 32'(BLC_MAX_CYC - `PEC_CYC_RD_ALL - 1);
          take      = req_valid && req_ready;
        end
        // A page left idle too long is closed, the device then commits it.
        if (blc_reg >= 32'(BLC_MAX_CYC - 1))
        begin
          open_next  = 1'b0;
          busy_next  = 1'b1;
          wc_next    = 32'h0;
          state_next = PEC_BUSY;
        end
      end
      PEC_RACC:
      begin
        if (ph_reg == 8'(`PEC_CYC_ACC - 1))
        begin
          ph_next    = 8'h00;
          state_next = PEC_RREL;
          if (poll_reg)
          begin
            pbit_next = din_sync[`PEC_POLL_BIT];
          end
          else
          begin
            rdat_next = din_sync;
            rv_next   = 1'b1;
          end
        end
      end
      PEC_RREL:
      begin
        // Bus left floating before the next drive.
        if (ph_reg == 8'(`PEC_CYC_HZ - 1))
        begin
          ph_next = 8'h00;
          if (poll_reg)
          begin
            poll_next = 1'b0;
            // Early end only on a true-data match.
            if (pbit_reg == wbit_reg || wc_reg >= 32'(WC_CYC - 1))
            begin
              busy_next  = 1'b0;
              state_next = PEC_IDLE;
            end
            else
            begin
              state_next = PEC_BUSY;
            end
          end
          else
          begin
            state_next = open_reg ? PEC_LOAD : PEC_IDLE;
          end
        end
      end
      PEC_WPUL:
      begin
        if (ph_reg == 8'(`PEC_CYC_WP - 1))
        begin
          ph_next    = 8'h00;
          state_next = PEC_WREC;
        end
      end
      PEC_WREC:
      begin
        if (ph_reg == 8'(`PEC_CYC_WPH - 1))
        begin
          ph_next = 8'h00;
          if (last_reg)
          begin
            open_next  = 1'b0;
            busy_next  = 1'b1;
            wc_next    = 32'h0;
            state_next = PEC_BUSY;
          end
          else
          begin
            open_next  = 1'b1;
            state_next = PEC_LOAD;
          end
        end
      end
      PEC_BUSY:
      begin
        // No access until the wait ends or a poll read says so.
        if (wc_reg >= 32'(WC_CYC - 1))
        begin
          busy_next  = 1'b0;
          state_next = PEC_IDLE;
        end
        else if (poll_en)
        begin
          // Poll is a plain read cycle.
          poll_next  = 1'b1;
          addr_next  = waddr_reg;
          ph_next    = 8'h00;
          state_next = PEC_RACC;
        end
      end
      default:
      begin
        state_next = PEC_IDLE;
      end
    endcase
    if (take)
    begin
      ph_next   = 8'h00;
      addr_next = req_addr;
      if (req_write)
      begin
        blc_next   = 32'h0;
        last_next  = req_last;
        wdat_next  = req_wdata;
        waddr_next = req_addr;
        wbit_next  = req_wdata[`PEC_POLL_BIT];
        state_next = PEC_WPUL;
      end
      else
      begin
        state_next = PEC_RACC;
      end
    end
  end

  // ****************************************************************
  // Pin strobes
  // ****************************************************************
  // Pins are registered from the next state so they never glitch.
  always_comb
  begin
    // Read is select and gate low, write is select and strobe low.
    ce_b_next = !(state_next == PEC_RACC || state_next == PEC_WPUL);
    oe_b_next = (state_next != PEC_RACC);
    we_b_next = (state_next != PEC_WPUL);
    doe_next  = (state_next == PEC_WPUL || state_next == PEC_WREC);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_reg <= PEC_IDLE;
      ph_reg    <= 8'h00;
      blc_reg   <= 32'h0;
      wc_reg    <= 32'h0;
      busy_reg  <= 1'b0;
      poll_reg  <= 1'b0;
      open_reg  <= 1'b0;
      last_reg  <= 1'b0;
      pbit_reg  <= 1'b0;
      wbit_reg  <= 1'b0;
      waddr_reg <= '0;
      addr_reg  <= '0;
      wdat_reg  <= '0;
      rdat_reg  <= '0;
      rv_reg    <= 1'b0;
      ce_b_reg  <= 1'b1;
      oe_b_reg  <= 1'b1;
      we_b_reg  <= 1'b1;
      doe_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ph_reg    <= ph_next;
      blc_reg   <= blc_next;
      wc_reg    <= wc_next;
      busy_reg  <= busy_next;
      poll_reg  <= poll_next;
      open_reg  <= open_next;
      last_reg  <= last_next;
      pbit_reg  <= pbit_next;
      wbit_reg  <= wbit_next;
      waddr_reg <= waddr_next;
      addr_reg  <= addr_next;
      wdat_reg  <= wdat_next;
      rdat_reg  <= rdat_next;
      rv_reg    <= rv_next;
      ce_b_reg  <= ce_b_next;
      oe_b_reg  <= oe_b_next;
      we_b_reg  <= we_b_next;
      doe_reg   <= doe_next;
    end
  end

  assign rsp_valid     = rv_reg;
  assign rsp_data      = rdat_reg;
  assign wr_busy       = busy_reg;
  assign mem_addr      = addr_reg;
  assign mem_ce_b      = ce_b_reg;
  assign mem_oe_b      = oe_b_reg;
  assign mem_we_b      = we_b_reg;
  assign data_pins_out = wdat_reg;
  assign data_pins_oe  = doe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper counters watch write strobe width and load spacing.
  // Spacing runs from one write strobe fall to the next, as loads are timed.
  logic [31:0] wlo_cnt;
  logic [31:0] gap_cnt;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wlo_cnt <= 32'h0;
      gap_cnt <= 32'h0;
    end
    else
    begin
      wlo_cnt <= mem_we_b ? 32'h0 : wlo_cnt + 32'h1;
      gap_cnt <= (!mem_we_b && $past(mem_we_b)) ? 32'h1 : gap_cnt + 32'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_no_gate_write: assert property (!(!mem_oe_b && !mem_we_b))
    else $error("Gate and write strobe low together.");
  a_no_drive_read: assert property (!mem_oe_b |-> !data_pins_oe)
    else $error("Host drives data during a read.");
  a_read_answer: assert property ($fell(mem_oe_b) && !poll_reg
    |-> ##30 (rsp_valid && $rose(mem_oe_b)))
    else $error("Read answer not 30 cycles after gate fall.");
  a_float_gap: assert property ($rose(mem_oe_b)
    |-> (mem_oe_b && !data_pins_oe)[*8])
    else $error("Data driven too soon after a read.");
  a_we_width: assert property ($rose(mem_we_b)
    |-> wlo_cnt == 32'(`PEC_CYC_WP))
    else $error("Write strobe width wrong.");
  a_load_spacing: assert property ($fell(mem_we_b) && open_reg
    |-> gap_cnt >= 32'(`PEC_CYC_BLC_MIN) && gap_cnt <= 32'(BLC_MAX_CYC))
    else $error("Byte loads spaced outside window.");
  a_busy_quiet: assert property (state_reg == PEC_BUSY
    |-> mem_ce_b && mem_we_b)
    else $error("Access during internal write wait.");
  a_wait_bound: assert property (busy_reg
    |-> wc_reg <= 32'(WC_CYC + `PEC_CYC_RD_ALL))
    else $error("Internal write wait overran.");
  a_poll_select: assert property (poll_reg && !mem_oe_b
    |-> !mem_ce_b && mem_we_b)
    else $error("Poll read without select low.");

  c_page_write: cover property ($fell(mem_we_b) && open_reg);
  c_gap_read: cover property (rsp_valid && open_reg);
  c_poll_done: cover property ($fell(busy_reg) && wc_reg < 32'(WC_CYC - 1));
  c_page_timeout: cover property (state_reg == PEC_LOAD
    && blc_reg >= 32'(BLC_MAX_CYC - 1));

endmodule

// *** pec_mem_model.sv ***
/*
  Behavioural model of the byte-wide self-timed memory.
  Assumes the bench resolves the shared data pins into dq_in.
*/
`timescale 1ns/1ps

module pec_mem_model
#(
  parameter real ACC_NS = 120.0,
  parameter real BLC_NS = 1000.0,
  parameter real BLC_MIN = 200.0
)
(
  input  wire logic        ce_b,
  input  wire logic        oe_b,
  input  wire logic        we_b,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             dq_oe
);
  logic [7:0]  mem [0:131071];
  logic [16:0] pg_a [$];
  logic [7:0]  pg_d [$];
  logic [7:0]  last_d = 8'h00;
  logic        busy = 1'b0;
  logic        armed = 1'b0;
  logic        acc_ok = 1'b0;
  real         ld_t = 0.0;
  real         wr_ns = 1200.0;
  int          pg_n = 0;
  int          viol_n = 0;
  int          busy_acc = 0;
  wire         wr_act = !ce_b && !we_b && oe_b;

  initial foreach (mem[i]) mem[i] = 8'hff;

  // ****
  // Read path
  // ****
  // Read decode and release.
  assign dq_oe = !ce_b && !oe_b && we_b;
  assign dq_out = acc_ok ? ((pg_n > 0) ? {~last_d[7], 7'h2a} : mem[addr])
                         : ~mem[addr];

  // Data is garbage until the access time runs out.
  always @(posedge dq_oe)
  begin
    acc_ok = 1'b0;
    #(ACC_NS) acc_ok = dq_oe;
  end
  always @(negedge dq_oe) acc_ok = 1'b0;

  always @(negedge ce_b) if (busy) busy_acc++;

  // ****
  // Write path
  // ****
  always @(posedge wr_act) armed = 1'b1;
  always @(negedge wr_act)
    if (armed && !busy)
    begin
      if (pg_n > 0 && $realtime - ld_t < BLC_MIN) viol_n++;
      pg_a.push_back(addr);
      pg_d.push_back(dq_in);
      last_d = dq_in;
      ld_t = $realtime;
      pg_n++;
      armed = 1'b0;
    end

  // Self-timed commit after the page window.
  initial forever
  begin
    wait (pg_n > 0);
    while ($realtime - ld_t < BLC_NS) #(BLC_NS - ($realtime - ld_t));
    busy = 1'b1;
    #(wr_ns);
    foreach (pg_a[i]) mem[pg_a[i]] = pg_d[i];
    pg_a.delete();
    pg_d.delete();
    pg_n = 0;
    busy = 1'b0;
  end
endmodule

// *** pec_testbench.sv ***
/*
  Self-checking bench for pec_ctrl with a behavioural memory.
  Assumes shortened write and page timeouts; data pins resolved here.
*/
`timescale 1ns/1ps

module testbench;
  localparam int WC  = 500;
  localparam int BLC = 200;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        req_last = 1'b0;
  logic [16:0] req_addr = 17'h00000;
  logic [7:0]  req_wdata = 8'h00;
  logic        poll_en = 1'b0;
  logic        req_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        wr_busy;
  logic [16:0] mem_addr;
  logic        mem_ce_b;
  logic        mem_oe_b;
  logic        mem_we_b;
  logic [7:0]  data_pins_out;
  logic        data_pins_oe;
  logic [7:0]  dq_out;
  logic        dq_oe;
  logic [7:0]  float_v = 8'h3c;
  int          num_errors = 0;
  int          tests_run = 0;
  // A released bus shows a pattern that changes every cycle.
  wire  [7:0]  bus = data_pins_oe ? data_pins_out : dq_oe ? dq_out : float_v;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) float_v <= ~float_v;

  pec_ctrl #(.WC_CYC(WC), .BLC_MAX_CYC(BLC)) i_dut
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_last(req_last),
    .req_addr(req_addr), .req_wdata(req_wdata), .poll_en(poll_en),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .wr_busy(wr_busy),
    .mem_addr(mem_addr), .mem_ce_b(mem_ce_b), .mem_oe_b(mem_oe_b),
    .mem_we_b(mem_we_b), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .data_pins_in(bus)
  );

  pec_mem_model i_mem
  (
    .ce_b(mem_ce_b), .oe_b(mem_oe_b), .we_b(mem_we_b), .addr(mem_addr),
    .dq_in(bus), .dq_out(dq_out), .dq_oe(dq_oe)
  );

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("Counts: %0d compared, %0d mismatched", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ****
  // Pin watch
  // ****
  always @(negedge clk_sys)
    if (rst_b)
    begin
      if (mem_oe_b === 1'b0 && mem_we_b === 1'b0) chk("oe_we", 0, 1);
      if (data_pins_oe === 1'b1 && dq_oe === 1'b1) chk("fight", 0, 1);
    end

  // ****
  // Bus tasks
  // ****
  task automatic send(input logic w, input logic l, input logic [16:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    // One edge passes first, so back-to-back calls never retoggle a strobe.
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_write = w;
    req_last = l;
    req_addr = a;
    req_wdata = d;
    #1;
    while (req_ready !== 1'b1 && n < 5000)
    begin
      @(negedge clk_sys);
      #1;
      n++;
    end
    chk("req_taken", 1, n < 5000);
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask

  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    int n;
    send(1'b0, 1'b0, a, 8'h00);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("read_latency", 30, n);
    chk("read_data", exp, rsp_data);
  endtask

  task automatic busy_len(output int rise, output int len);
    rise = 0;
    while (wr_busy !== 1'b1 && rise < 2000)
    begin
      @(negedge clk_sys);
      rise++;
    end
    chk("busy_refuse", 0, req_ready);
    len = 0;
    while (wr_busy === 1'b1 && len < 5000)
    begin
      @(negedge clk_sys);
      len++;
    end
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk("strobes", 3'b111, {mem_ce_b, mem_oe_b, mem_we_b});
    chk("drive_idle", 0, data_pins_oe);
    rd(17'h00010, 8'hff);
    $display("test reset_read done");
  endtask

  task automatic t_byte();
    int r;
    int len;
    int acc0;
    acc0 = i_mem.busy_acc;
    send(1'b1, 1'b1, 17'h10003, 8'ha5);
    busy_len(r, len);
    chk("wait_full", 1, len >= WC && len <= WC + 2);
    chk("model_done", 0, i_mem.busy);
    chk("quiet_busy", acc0, i_mem.busy_acc);
    rd(17'h10003, 8'ha5);
    $display("test byte_write done");
  endtask

  task automatic t_window();
    int r;
    int len;
    send(1'b1, 1'b0, 17'h00200, 8'h4e);
    rd(17'h00200, 8'haa);
    send(1'b1, 1'b1, 17'h00201, 8'hc1);
    busy_len(r, len);
    rd(17'h00200, 8'h4e);
    rd(17'h00201, 8'hc1);
    $display("test window_read done");
  endtask

  task automatic t_page();
    int r;
    int len;
    int acc0;
    int v0;
    i_mem.wr_ns = 300.0;
    poll_en = 1'b1;
    acc0 = i_mem.busy_acc;
    v0 = i_mem.viol_n;
    for (int i = 0; i < 4; i++)
      send(1'b1, i == 3, 17'h00100 + i[16:0], 8'h30 + i[7:0]);
    busy_len(r, len);
    chk("poll_early", 1, len < WC);
    chk("poll_reads", 1, i_mem.busy_acc > acc0);
    chk("model_done", 0, i_mem.busy);
    chk("load_spacing", v0, i_mem.viol_n);
    for (int i = 0; i < 4; i++)
      rd(17'h00100 + i[16:0], 8'h30 + i[7:0]);
    i_mem.wr_ns = 1200.0;
    poll_en = 1'b0;
    $display("test page_poll done");
  endtask

  task automatic t_timeout();
    int r;
    int len;
    send(1'b1, 1'b0, 17'h1ffff, 8'h5a);
    busy_len(r, len);
    chk("page_close", 1, r > BLC - 10 && r < BLC + 60);
    chk("model_done", 0, i_mem.busy);
    rd(17'h1ffff, 8'h5a);
    $display("test page_timeout done");
  endtask

  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_byte();
    t_window();
    t_page();
    t_timeout();
    stop_test();
  end

  // The tests need about 2600 cycles; this allows several times that.
  initial
  begin
    #100000;
    chk("watchdog", 0, 1);
    stop_test();
  end
endmodule
